// ===== bench/spm_core_model.sv
// core model: sleep requests, handler return and held wake sources
`timescale 1ns/10ps
module spm_core_model (
    input wire logic CLK,
    output logic SLEEP_REQ,
    output logic HANDLER_EXIT,
    output logic DEEP_SLEEP_SELECT,
    output logic IDLE_AFTER_HANDLER_RETURN,
    output logic WAKE_EXCEPTION,
    output logic WAKE_AHB_IRQ,
    output logic WAKE_APB_IRQ,
    output logic WAKE_ASYNC_IRQ
);
    // ==========================================================================
    // quiet core at time zero
    initial begin
        {SLEEP_REQ, HANDLER_EXIT, DEEP_SLEEP_SELECT, IDLE_AFTER_HANDLER_RETURN} = 4'h0;
        {WAKE_EXCEPTION, WAKE_AHB_IRQ, WAKE_APB_IRQ, WAKE_ASYNC_IRQ} = 4'h0;
    end
    task automatic enter_sleep(input logic deep);
        @(posedge CLK);
        DEEP_SLEEP_SELECT <= deep;
        @(posedge CLK);
        SLEEP_REQ <= 1'b1;
        @(posedge CLK);
        SLEEP_REQ <= 1'b0;
    endtask : enter_sleep
    task automatic leave_handler(input logic on);
        @(posedge CLK);
        DEEP_SLEEP_SELECT <= 1'b0;
        IDLE_AFTER_HANDLER_RETURN <= on;
        HANDLER_EXIT <= 1'b1;
        @(posedge CLK);
        HANDLER_EXIT <= 1'b0;
    endtask : leave_handler
    // sources {async, apb, ahb} held eight cycles, then released
    task automatic raise_wake(input logic [2:0] src, input logic exc);
        @(posedge CLK);
        {WAKE_ASYNC_IRQ, WAKE_APB_IRQ, WAKE_AHB_IRQ} <= src;
        WAKE_EXCEPTION <= exc;
        repeat (8) @(posedge CLK);
        {WAKE_ASYNC_IRQ, WAKE_APB_IRQ, WAKE_AHB_IRQ} <= 3'h0;
        WAKE_EXCEPTION <= 1'b0;
    endtask : raise_wake
endmodule : spm_core_model

// ===== bench/spm_sva.sv
// concurrent checks on the sleep power manager ports
`timescale 1ns/10ps
module spm_sva (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP_SELECT,
    input wire logic WAKE_EXCEPTION,
    input wire logic WAKE_ASYNC_IRQ,
    input wire logic CPU_CLK_EN,
    input wire logic AHB_CLK_EN,
    input wire logic BUS_A_CLK_EN,
    input wire logic BUS_B_CLK_EN,
    input wire logic BUS_C_CLK_EN,
    input wire logic [31:0] HS_MODULE_EN,
    input wire logic [31:0] A_MODULE_EN,
    input wire logic [31:0] B_MODULE_EN,
    input wire logic [31:0] C_MODULE_EN,
    input wire logic REG_LOW_POWER,
    input wire logic RAM_LOW_POWER,
    input wire logic IRQ
);
    // ==========================================================================
    // clocking and request sequences
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    sequence s_deep_req;
        SLEEP_REQ && DEEP_SLEEP_SELECT && !REG_LOW_POWER;
    endsequence
    sequence s_idle_req;
        SLEEP_REQ && !DEEP_SLEEP_SELECT && !REG_LOW_POWER;
    endsequence
    sequence s_en_off;
        WR && ADDR == spm_pkg::OFS_INT_EN_CLR && WDATA[0];
    endsequence
    // ==========================================================================
    // assertions
    a_standby_entry: assert property (
        s_deep_req |-> ##2 REG_LOW_POWER && RAM_LOW_POWER)
        else $error("standby not entered after deep request");
    a_standby_cause: assert property (
        $rose(REG_LOW_POWER) |-> $past(SLEEP_REQ, 2) && $past(DEEP_SLEEP_SELECT, 2))
        else $error("low power without deep sleep request");
    a_idle_regulator: assert property (
        s_idle_req |-> ##2 !REG_LOW_POWER [*4])
        else $error("regulator left normal mode in idle");
    a_standby_clocks: assert property (
        REG_LOW_POWER |-> !(CPU_CLK_EN || AHB_CLK_EN || BUS_A_CLK_EN || BUS_B_CLK_EN
        || BUS_C_CLK_EN))
        else $error("domain clock running in standby");
    a_standby_gates: assert property (
        REG_LOW_POWER |-> (HS_MODULE_EN | A_MODULE_EN | B_MODULE_EN | C_MODULE_EN) == 32'h0)
        else $error("module enabled in standby");
    a_async_wake: assert property (
        $fell(REG_LOW_POWER) |-> $past(WAKE_ASYNC_IRQ, 2))
        else $error("standby left without asynchronous wake");
    a_wake_exception: assert property (
        $fell(REG_LOW_POWER) |-> $past(WAKE_EXCEPTION, 2))
        else $error("wake without exception entry");
    a_irq_disable: assert property (
        s_en_off |-> ##2 !IRQ)
        else $error("interrupt still high after disable");
    a_irq_hold: assert property (
        $fell(IRQ) |-> $past(WR) || $past(WR, 2))
        else $error("interrupt dropped without a write");
    a_read_quiet: assert property (
        !$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read cycle");
    a_reset_quiet: assert property (
        $fell(SRST) |-> !IRQ && !REG_LOW_POWER && HS_MODULE_EN == 32'h0)
        else $error("outputs active after reset");
endmodule : spm_sva
bind spm_top spm_sva spm_sva_i (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .SLEEP_REQ,
    .DEEP_SLEEP_SELECT, .WAKE_EXCEPTION, .WAKE_ASYNC_IRQ, .CPU_CLK_EN, .AHB_CLK_EN,
    .BUS_A_CLK_EN, .BUS_B_CLK_EN, .BUS_C_CLK_EN, .HS_MODULE_EN, .A_MODULE_EN, .B_MODULE_EN,
    .C_MODULE_EN, .REG_LOW_POWER, .RAM_LOW_POWER, .IRQ);

// ===== bench/spm_top_tb.sv
// self-checking testbench of the sleep power manager
`timescale 1ns/10ps
module spm_top_tb;
    // ==========================================================================
    // signals and tables
    logic CLK, SRST, WR, RD, RESET_CAUSE_VALID;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, HS_MODULE_EN, A_MODULE_EN, B_MODULE_EN, C_MODULE_EN;
    logic [5:0] RESET_CAUSE_IN, cause;
    logic [3:0] OSC_REQUEST, OSC_RUN, keep, ond;
    logic CPU_CLK_EN, AHB_CLK_EN, BUS_A_CLK_EN, BUS_B_CLK_EN, BUS_C_CLK_EN, IRQ;
    logic REG_LOW_POWER, RAM_LOW_POWER, SLEEP_REQ, HANDLER_EXIT, DEEP_SLEEP_SELECT;
    logic IDLE_AFTER_HANDLER_RETURN, WAKE_EXCEPTION, WAKE_AHB_IRQ, WAKE_APB_IRQ, WAKE_ASYNC_IRQ;
    logic [31:0] gate [4];
    int fail_count, total_checks, seed, nc, na, ad;
    localparam logic [31:0] gate_mask [4] = '{32'h7f, 32'h7f, 32'h3f, 32'h013f_ffff};
    localparam logic [7:0] rst_addr [13] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h14,
        8'h18, 8'h1c, 8'h20, 8'h38, 8'h3c, 8'h44};
    localparam logic [31:0] rst_val [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7f,
        32'h7f, 32'h7f, 32'h0001_0000, 32'h1, 32'h0, 32'h1};
    localparam logic [2:0] bad_src [5] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3};
    localparam logic [2:0] good_src [5] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h4};
    spm_top spm_top_i (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .SLEEP_REQ, .HANDLER_EXIT,
        .DEEP_SLEEP_SELECT, .IDLE_AFTER_HANDLER_RETURN, .WAKE_EXCEPTION, .WAKE_AHB_IRQ,
        .WAKE_APB_IRQ, .WAKE_ASYNC_IRQ, .RESET_CAUSE_IN, .RESET_CAUSE_VALID, .OSC_REQUEST,
        .CPU_CLK_EN, .AHB_CLK_EN, .BUS_A_CLK_EN, .BUS_B_CLK_EN, .BUS_C_CLK_EN, .HS_MODULE_EN,
        .A_MODULE_EN, .B_MODULE_EN, .C_MODULE_EN, .OSC_RUN, .REG_LOW_POWER, .RAM_LOW_POWER, .IRQ);
    spm_core_model spm_core_model_i (.CLK, .SLEEP_REQ, .HANDLER_EXIT, .DEEP_SLEEP_SELECT,
        .IDLE_AFTER_HANDLER_RETURN, .WAKE_EXCEPTION, .WAKE_AHB_IRQ, .WAKE_APB_IRQ,
        .WAKE_ASYNC_IRQ);
    // ==========================================================================
    // expectations, bus tasks and verdict
    function automatic logic [31:0] state_exp(input int k);
        return 32'h1 << ((k >= 3) ? k : k + 1);
    endfunction : state_exp
    function automatic logic [3:0] osc_exp(input logic sb);
        return sb ? (keep & (~ond | OSC_REQUEST)) : (~ond | OSC_REQUEST);
    endfunction : osc_exp
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check(RDATA, exp);
    endtask : rd_chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // clock of 8 ns
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // watchdog far beyond the run length
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        final_report();
    end
    // main sequence
    initial begin
        {SRST, WR, RD, RESET_CAUSE_VALID} = 4'h8;
        ADDR = 8'h0;
        WDATA = 32'h0;
        RESET_CAUSE_IN = 6'h0;
        fail_count = 0;
        total_checks = 0;
        seed = $urandom(32'h2fc4);
        OSC_REQUEST = 4'($urandom());
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        wr(8'h3c, $urandom());
        foreach (rst_addr[i]) begin
            rd_chk(rst_addr[i], rst_val[i]);
        end
        for (int i = 0; i < 4; i++) begin
            gate[i] = $urandom() & gate_mask[i];
            wr(8'h14 + 8'(4 * i), gate[i]);
            rd_chk(8'h14 + 8'(4 * i), gate[i]);
        end
        cause = 6'h1 << ($urandom() % 6);
        @(posedge CLK);
        RESET_CAUSE_IN <= cause;
        RESET_CAUSE_VALID <= 1'b1;
        @(posedge CLK);
        RESET_CAUSE_VALID <= 1'b0;
        rd_chk(8'h38, {25'h0, cause[5:3], 1'b0, cause[2:0]});
        // every cpu divider value with a random bus A divider, ready flag and interrupt handling
        wr(8'h35, 32'h1);
        for (int d = 0; d < 8; d++) begin
            ad = d + int'($urandom() % (8 - d));
            wr(8'h08, d);
            wr(8'h09, ad);
            rd_chk(8'h36, 32'h0);
            settle(12);
            rd_chk(8'h36, 32'h1);
            check(IRQ, 1'b1);
            nc = 0;
            na = 0;
            repeat (128) begin
                settle(1);
                nc += CPU_CLK_EN;
                na += BUS_A_CLK_EN;
            end
            check(nc, 128 >> d);
            check(na, 128 >> ad);
            wr(8'h36, 32'h0);
            wr(8'h34, 32'h0);
            check(IRQ, 1'b1);
            wr(d[0] ? 8'h34 : 8'h36, 32'h1);
            settle(2);
            check(IRQ, 1'b0);
            wr(8'h35, 32'h1);
        end
        // idle levels and standby: refused wake, then accepted wake
        {keep, ond} = 8'($urandom());
        wr(8'h40, {20'h0, ond, 4'h0, keep});
        for (int k = 0; k < 5; k++) begin
            if (k == 4) begin
                wr(8'h20, 32'h0);
            end else begin
                wr(8'h01, k);
            end
            spm_core_model_i.enter_sleep(k == 4);
            settle(3);
            rd_chk(8'h44, state_exp(k));
            check(HS_MODULE_EN, (k == 0) ? gate[0] : 32'h0);
            check(A_MODULE_EN, (k <= 1) ? gate[1] : 32'h0);
            check({REG_LOW_POWER, RAM_LOW_POWER, OSC_RUN}, {k == 4, k == 4, osc_exp(k == 4)});
            spm_core_model_i.raise_wake(bad_src[k], k != 0);
            settle(2);
            rd_chk(8'h44, state_exp(k));
            spm_core_model_i.raise_wake(good_src[k], 1'b1);
            rd_chk(8'h44, 32'h1);
        end
        wr(8'h01, 32'h2);
        spm_core_model_i.leave_handler(1'b0);
        rd_chk(8'h44, 32'h1);
        spm_core_model_i.leave_handler(1'b1);
        settle(3);
        rd_chk(8'h44, 32'h8);
        spm_core_model_i.raise_wake(3'h4, 1'b1);
        // second reset in mid-run
        @(posedge CLK);
        SRST <= 1'b1;
        repeat (3) @(posedge CLK);
        SRST <= 1'b0;
        rd_chk(8'h14, 32'h7f);
        final_report();
    end
endmodule : spm_top_tb

// ===== hdl/spm_top.sv
// sleep power manager: sleep control, clock gating, prescalers, interrupt and registers
//
// Notes on behaviour
// - sleep on wait-for-interrupt or handler return, level from config
// - idle stops cpu clock, regulator normal
// - wake sources narrow as idle level rises
// - standby stops clocks, regulator and ram low-power
// - standby wakes only on asynchronous interrupts
// - idle halts domains regardless of gate masks
// - idle also entered on handler return
// - qualified interrupt returns to active mode
// - manager itself keeps running in idle
// - clock ready flag sets when setting effective
// - enable set/clear by writing ones
// - request high while flag and enable set
// - writing one clears the flag
// - ready flag reads zero until setting effective
// - cpu and bus clocks divide by power of two
// - reset cause shows most recent source
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module spm_top (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic SLEEP_REQ,
    input wire logic HANDLER_EXIT,
    input wire logic DEEP_SLEEP_SELECT,
    input wire logic IDLE_AFTER_HANDLER_RETURN,
    input wire logic WAKE_EXCEPTION,
    input wire logic WAKE_AHB_IRQ,
    input wire logic WAKE_APB_IRQ,
    input wire logic WAKE_ASYNC_IRQ,
    input wire logic [5:0] RESET_CAUSE_IN,
    input wire logic RESET_CAUSE_VALID,
    input wire logic [3:0] OSC_REQUEST,
    output logic CPU_CLK_EN,
    output logic AHB_CLK_EN,
    output logic BUS_A_CLK_EN,
    output logic BUS_B_CLK_EN,
    output logic BUS_C_CLK_EN,
    output logic [31:0] HS_MODULE_EN,
    output logic [31:0] A_MODULE_EN,
    output logic [31:0] B_MODULE_EN,
    output logic [31:0] C_MODULE_EN,
    output logic [3:0] OSC_RUN,
    output logic REG_LOW_POWER,
    output logic RAM_LOW_POWER,
    output logic IRQ
);
    // ==========================================================================
    // input synchronisers for asynchronous wake and oscillator requests
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync_next;
    logic async_wake;
    logic [3:0] osc_req;
    always_comb begin
        sync_next = {OSC_REQUEST, WAKE_ASYNC_IRQ};
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1_reg <= 5'h0_0;
            sync2_reg <= 5'h0_0;
        end else begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end
    assign async_wake = sync2_reg[0];
    assign osc_req = sync2_reg[4:1];

    // ==========================================================================
    // register file
    logic [1:0] sleep_level_config_reg, sleep_level_config_next;
    logic [2:0] cpu_div_reg, cpu_div_next;
    logic [2:0] a_div_reg, a_div_next;
    logic [2:0] b_div_reg, b_div_next;
    logic [2:0] c_div_reg, c_div_next;
    logic [31:0] hs_gates_reg, hs_gates_next;
    logic [31:0] a_gates_reg, a_gates_next;
    logic [31:0] b_gates_reg, b_gates_next;
    logic [31:0] c_gates_reg, c_gates_next;
    logic int_en_reg, int_en_next;
    logic int_flag_reg, int_flag_next;
    logic [7:0] reset_src_reg, reset_src_next;
    logic [3:0] osc_standby_reg, osc_standby_next;
    logic [3:0] osc_run_only_when_requested_reg, osc_run_only_when_requested_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [3:0] settle_cnt_reg, settle_cnt_next;
    logic ready_pulse;
    logic div_write;
    spm_pkg::spm_state_t state_reg, state_next;

    assign div_write = WR && (ADDR == spm_pkg::OFS_CPU_DIV || ADDR == spm_pkg::OFS_BUS_A_DIV
        || ADDR == spm_pkg::OFS_BUS_B_DIV || ADDR == spm_pkg::OFS_BUS_C_DIV);

    // register writes and read mux
    always_comb begin
        sleep_level_config_next = sleep_level_config_reg;
        cpu_div_next = cpu_div_reg;
        a_div_next = a_div_reg;
        b_div_next = b_div_reg;
        c_div_next = c_div_reg;
        hs_gates_next = hs_gates_reg;
        a_gates_next = a_gates_reg;
        b_gates_next = b_gates_reg;
        c_gates_next = c_gates_reg;
        int_en_next = int_en_reg;
        int_flag_next = int_flag_reg;
        reset_src_next = reset_src_reg;
        osc_standby_next = osc_standby_reg;
        osc_run_only_when_requested_next = osc_run_only_when_requested_reg;
        rdata_next = 32'h0000_0000;
        if (WR) begin
            unique case (ADDR)
                spm_pkg::OFS_SLEEP_CFG: sleep_level_config_next = WDATA[1:0];
                spm_pkg::OFS_CPU_DIV: cpu_div_next = WDATA[2:0];
                spm_pkg::OFS_BUS_A_DIV: a_div_next = WDATA[2:0];
                spm_pkg::OFS_BUS_B_DIV: b_div_next = WDATA[2:0];
                spm_pkg::OFS_BUS_C_DIV: c_div_next = WDATA[2:0];
                spm_pkg::OFS_HS_GATES: hs_gates_next = WDATA;
                spm_pkg::OFS_A_GATES: a_gates_next = WDATA;
                spm_pkg::OFS_B_GATES: b_gates_next = WDATA;
                spm_pkg::OFS_C_GATES: c_gates_next = WDATA;
                spm_pkg::OFS_INT_EN_CLR: int_en_next = int_en_reg & ~WDATA[0];
                spm_pkg::OFS_INT_EN_SET: int_en_next = int_en_reg | WDATA[0];
                spm_pkg::OFS_INT_FLAGS: int_flag_next = int_flag_reg & ~WDATA[0];
                spm_pkg::OFS_OSC_CFG: begin
                    osc_standby_next = WDATA[3:0];
                    osc_run_only_when_requested_next = WDATA[11:8];
                end
                default: ;
            endcase
        end
        // flag reads zero while a new setting settles
        if (div_write) begin
            int_flag_next = 1'b0;
        end
        // set wins over a same-cycle clear
        if (ready_pulse) begin
            int_flag_next = 1'b1;
        end
        if (RESET_CAUSE_VALID) begin
            reset_src_next = {1'b0, RESET_CAUSE_IN[5:3], 1'b0, RESET_CAUSE_IN[2:0]};
        end
        if (RD) begin
            unique case (ADDR)
                spm_pkg::OFS_SLEEP_CFG: rdata_next = {30'h0, sleep_level_config_reg};
                spm_pkg::OFS_CPU_DIV: rdata_next = {29'h0, cpu_div_reg};
                spm_pkg::OFS_BUS_A_DIV: rdata_next = {29'h0, a_div_reg};
                spm_pkg::OFS_BUS_B_DIV: rdata_next = {29'h0, b_div_reg};
                spm_pkg::OFS_BUS_C_DIV: rdata_next = {29'h0, c_div_reg};
                spm_pkg::OFS_HS_GATES: rdata_next = hs_gates_reg;
                spm_pkg::OFS_A_GATES: rdata_next = a_gates_reg;
                spm_pkg::OFS_B_GATES: rdata_next = b_gates_reg;
                spm_pkg::OFS_C_GATES: rdata_next = c_gates_reg;
                spm_pkg::OFS_INT_EN_CLR: rdata_next = {31'h0, int_en_reg};
                spm_pkg::OFS_INT_EN_SET: rdata_next = {31'h0, int_en_reg};
                spm_pkg::OFS_INT_FLAGS: rdata_next = {31'h0, int_flag_reg};
                spm_pkg::OFS_RESET_SRC: rdata_next = {24'h0, reset_src_reg};
                spm_pkg::OFS_OSC_CFG: rdata_next = {20'h0, osc_run_only_when_requested_reg, 4'h0, osc_standby_reg};
                spm_pkg::OFS_POWER_STAT: rdata_next = {27'h0, state_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sleep_level_config_reg <= spm_pkg::IDLE_CPU;
            cpu_div_reg <= 3'h0;
            a_div_reg <= 3'h0;
            b_div_reg <= 3'h0;
            c_div_reg <= 3'h0;
            hs_gates_reg <= spm_pkg::HS_GATES_RST;
            a_gates_reg <= spm_pkg::A_GATES_RST;
            b_gates_reg <= spm_pkg::B_GATES_RST;
            c_gates_reg <= spm_pkg::C_GATES_RST;
            int_en_reg <= 1'b0;
            int_flag_reg <= 1'b0;
            reset_src_reg <= spm_pkg::RESET_SRC_RST;
            osc_standby_reg <= 4'h0;
            osc_run_only_when_requested_reg <= 4'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            sleep_level_config_reg <= sleep_level_config_next;
            cpu_div_reg <= cpu_div_next;
            a_div_reg <= a_div_next;
            b_div_reg <= b_div_next;
            c_div_reg <= c_div_next;
            hs_gates_reg <= hs_gates_next;
            a_gates_reg <= a_gates_next;
            b_gates_reg <= b_gates_next;
            c_gates_reg <= c_gates_next;
            int_en_reg <= int_en_next;
            int_flag_reg <= int_flag_next;
            reset_src_reg <= reset_src_next;
            osc_standby_reg <= osc_standby_next;
            osc_run_only_when_requested_reg <= osc_run_only_when_requested_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================================
    // settle counter for new divider settings
    always_comb begin
        settle_cnt_next = settle_cnt_reg;
        ready_pulse = 1'b0;
        if (div_write) begin
            settle_cnt_next = 4'(spm_pkg::SETTLE_CYC);
        end else if (settle_cnt_reg != 4'h0) begin
            settle_cnt_next = settle_cnt_reg - 4'h1;
            ready_pulse = (settle_cnt_reg == 4'h1);
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            settle_cnt_reg <= 4'h0;
        end else begin
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    // ==========================================================================
    // free running prescaler; each domain ticks on 2^div
    logic [7:0] pre_reg, pre_next;
    logic [3:0] tick;
    logic [2:0] divs [4];
    assign divs[0] = cpu_div_reg;
    assign divs[1] = a_div_reg;
    assign divs[2] = b_div_reg;
    assign divs[3] = c_div_reg;
    always_comb begin
        pre_next = pre_reg + 8'h01;
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pre_reg <= 8'h00;
        end else begin
            pre_reg <= pre_next;
        end
    end
    // tick when the low div bits are all ones
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tick
            assign tick[gi] = ((pre_reg | ~(8'hff >> (4'h8 - {1'b0, divs[gi]}))) == 8'hff);
        end
    endgenerate

    // ==========================================================================
    // power state machine
    logic wake;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            spm_pkg::ST_IDLE0: wake = WAKE_EXCEPTION && (WAKE_AHB_IRQ || WAKE_APB_IRQ || async_wake);
            spm_pkg::ST_IDLE1: wake = WAKE_EXCEPTION && (WAKE_APB_IRQ || async_wake);
            spm_pkg::ST_IDLE2: wake = WAKE_EXCEPTION && async_wake;
            spm_pkg::ST_STANDBY: wake = WAKE_EXCEPTION && async_wake;
            default: wake = 1'b0;
        endcase
        unique case (state_reg)
            spm_pkg::ST_ACTIVE: begin
                // enter on instruction or handler return
                if (SLEEP_REQ || (HANDLER_EXIT && IDLE_AFTER_HANDLER_RETURN)) begin
                    if (DEEP_SLEEP_SELECT) begin
                        state_next = spm_pkg::ST_STANDBY;
                    end else if (sleep_level_config_reg == spm_pkg::IDLE_CPU) begin
                        state_next = spm_pkg::ST_IDLE0;
                    end else if (sleep_level_config_reg == spm_pkg::IDLE_AHB) begin
                        state_next = spm_pkg::ST_IDLE1;
                    end else begin
                        state_next = spm_pkg::ST_IDLE2;
                    end
                end
            end
            default: if (wake) state_next = spm_pkg::ST_ACTIVE;
        endcase
    end
    // this logic runs on the main clock in every state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= spm_pkg::ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================================
    // registered outputs
    logic run_cpu, run_ahb, run_apb, sby;
    logic [4:0] en_next;
    logic [3:0] osc_next;
    logic irq_next;
    always_comb begin
        run_cpu = (state_reg == spm_pkg::ST_ACTIVE);
        run_ahb = run_cpu || state_reg == spm_pkg::ST_IDLE0;
        run_apb = run_ahb || state_reg == spm_pkg::ST_IDLE1;
        sby = (state_reg == spm_pkg::ST_STANDBY);
        en_next = {run_apb & tick[3], run_apb & tick[2], run_apb & tick[1],
            run_ahb & tick[0], run_cpu & tick[0]};
        for (int i = 0; i < spm_pkg::NUM_OSC; i++) begin
            if (sby) begin
                osc_next[i] = osc_standby_reg[i] && (!osc_run_only_when_requested_reg[i] || osc_req[i]);
            end else begin
                osc_next[i] = !osc_run_only_when_requested_reg[i] || osc_req[i];
            end
        end
        irq_next = int_flag_next && int_en_next;
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CPU_CLK_EN <= 1'b0;
            AHB_CLK_EN <= 1'b0;
            BUS_A_CLK_EN <= 1'b0;
            BUS_B_CLK_EN <= 1'b0;
            BUS_C_CLK_EN <= 1'b0;
            HS_MODULE_EN <= 32'h0000_0000;
            A_MODULE_EN <= 32'h0000_0000;
            B_MODULE_EN <= 32'h0000_0000;
            C_MODULE_EN <= 32'h0000_0000;
            OSC_RUN <= 4'h0;
            REG_LOW_POWER <= 1'b0;
            RAM_LOW_POWER <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            {BUS_C_CLK_EN, BUS_B_CLK_EN, BUS_A_CLK_EN, AHB_CLK_EN, CPU_CLK_EN} <= en_next;
            // stopped domains override the gate masks
            HS_MODULE_EN <= hs_gates_reg & {32{run_ahb}};
            A_MODULE_EN <= a_gates_reg & {32{run_apb}};
            B_MODULE_EN <= b_gates_reg & {32{run_apb}};
            C_MODULE_EN <= c_gates_reg & {32{run_apb}};
            OSC_RUN <= osc_next;
            REG_LOW_POWER <= sby;
            RAM_LOW_POWER <= sby;
            IRQ <= irq_next;
        end
    end
    assign RDATA = rdata_reg;
endmodule : spm_top

// ===== inc/spm_pkg.sv
// package of register map, field layout and timing constants for the sleep power manager
package spm_pkg;
    // ==========================================================================
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h01;
    localparam logic [7:0] OFS_CPU_DIV = 8'h08;
    localparam logic [7:0] OFS_BUS_A_DIV = 8'h09;
    localparam logic [7:0] OFS_BUS_B_DIV = 8'h0a;
    localparam logic [7:0] OFS_BUS_C_DIV = 8'h0b;
    localparam logic [7:0] OFS_HS_GATES = 8'h14;
    localparam logic [7:0] OFS_A_GATES = 8'h18;
    localparam logic [7:0] OFS_B_GATES = 8'h1c;
    localparam logic [7:0] OFS_C_GATES = 8'h20;
    localparam logic [7:0] OFS_INT_EN_CLR = 8'h34;
    localparam logic [7:0] OFS_INT_EN_SET = 8'h35;
    localparam logic [7:0] OFS_INT_FLAGS = 8'h36;
    localparam logic [7:0] OFS_RESET_SRC = 8'h38;
    localparam logic [7:0] OFS_OSC_CFG = 8'h40;
    localparam logic [7:0] OFS_POWER_STAT = 8'h44;
    // ==========================================================================
    // field positions and widths
    localparam int IDLE_LEVEL_W = 2;
    localparam int DIV_W = 3;
    localparam int PRESCALE_W = 8;
    localparam int BIT_CLOCK_READY = 0;
    localparam int NUM_OSC = 4;
    localparam int NUM_CAUSE = 6;
    // reset cause bit positions
    localparam int CAUSE_POWER_ON = 0;
    localparam int CAUSE_CORE_BROWNOUT = 1;
    localparam int CAUSE_IO_BROWNOUT = 2;
    localparam int CAUSE_EXTERNAL_PIN = 4;
    localparam int CAUSE_WATCHDOG = 5;
    localparam int CAUSE_SOFTWARE_REQ = 6;
    // ==========================================================================
    // reset values
    localparam logic [31:0] HS_GATES_RST = 32'h0000_007f;
    localparam logic [31:0] A_GATES_RST = 32'h0000_007f;
    localparam logic [31:0] B_GATES_RST = 32'h0000_007f;
    localparam logic [31:0] C_GATES_RST = 32'h0001_0000;
    localparam logic [7:0] RESET_SRC_RST = 8'h01;
    // idle level codes
    localparam logic [1:0] IDLE_CPU = 2'h0;
    localparam logic [1:0] IDLE_AHB = 2'h1;
    localparam logic [1:0] IDLE_APB = 2'h2;
    // ==========================================================================
    // clock ready settle delay after a divider write
    localparam int SETTLE_NS = 64;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 4;
    // power states, one-hot
    typedef enum logic [4:0] {
        ST_ACTIVE = 5'b00001,
        ST_IDLE0 = 5'b00010,
        ST_IDLE1 = 5'b00100,
        ST_IDLE2 = 5'b01000,
        ST_STANDBY = 5'b10000
    } spm_state_t;
endpackage : spm_pkg
